// [verification/nfh_dev_model.sv]
// Purpose: Behavioural NAND flash device facing the host sequencer.
// Assumes: Open-drain busy line with pull-up; pins act on their strobe edges.
// Notes:   One block reads as bad; fail_next makes the next program or erase fail.
`timescale 1ns/1ps
`default_nettype none
module nfh_dev_model #(
    parameter int BUSY_NS = 2000,
    parameter int BAD_BLK = 2
) (
    // Control pins
    input wire logic       chip_en_n,
    input wire logic       cmd_latch,
    input wire logic       addr_latch,
    input wire logic       wr_en_n,
    input wire logic       rd_en_n,
    input wire logic       wr_prot_n,
    input wire logic [7:0] io_bus,
    // Fault injection
    input wire logic       fail_next,
    // Device outputs
    output logic           ready_busy_line,
    output logic [7:0]     dev_io
);
    logic [7:0]  mem [16];
    logic [7:0]  adr [5];
    logic [7:0]  cmd_q;
    logic [23:0] row;
    logic        fail_q;
    logic        stat_mode;
    int          n_adr;
    int          col;
    event        go_busy;
    assign row = {adr[4], adr[3], adr[2]};
    initial begin
        mem = '{default: 8'hFF};
        adr = '{default: 8'h00};
        cmd_q = 8'h00;
        fail_q = 1'b0;
        stat_mode = 1'b0;
        n_adr = 0;
        col = 0;
        dev_io = 8'h5A;
        ready_busy_line = 1'b0;
        #(BUSY_NS) ready_busy_line = 1'b1;
    end
    always begin : busy_blk
        @(go_busy);
        ready_busy_line = 1'b0;
        #(BUSY_NS) ready_busy_line = 1'b1;
    end
    always @(negedge wr_prot_n) begin
        if (cmd_q inside {8'h10, 8'hD0} && !ready_busy_line) begin
            disable busy_blk;
            ready_busy_line = 1'b1;
        end
    end
    // --------
    // Write strobe: command, address and data cycles.
    // --------
    always @(posedge wr_en_n) begin
        if (!chip_en_n && cmd_latch) begin
            if (io_bus inside {8'h70, 8'h71}) begin
                stat_mode = 1'b1;
            end else begin
                stat_mode = 1'b0;
                n_adr = 0;
                cmd_q = io_bus;
                if (io_bus == 8'hFF) begin
                    disable busy_blk;
                    ready_busy_line = 1'b1;
                    fail_q = 1'b0;
                end
                if (io_bus inside {8'h10, 8'hD0}) fail_q = fail_next;
                if (io_bus inside {8'h30, 8'h10, 8'hD0, 8'hFF}) ->> go_busy;
            end
        end else if (!chip_en_n && addr_latch) begin
            if (n_adr == 0) col = io_bus;
            if (n_adr < 5) adr[n_adr] = io_bus;
            n_adr++;
        end else if (!chip_en_n && cmd_q == 8'h80) begin
            mem[{adr[2][0], col[2:0]}] = io_bus;
            col++;
        end
    end
    always @(negedge rd_en_n) begin
        if (!chip_en_n && stat_mode) begin
            dev_io = {wr_prot_n, {2{ready_busy_line}}, 4'h0, ready_busy_line & fail_q};
        end else if (!chip_en_n) begin
            dev_io = (row[23:6] == BAD_BLK) ? 8'h00 : mem[{adr[2][0], col[2:0]}];
            col++;
        end
    end
    // Released data lines do not keep their last value.
    always @(posedge rd_en_n) #15 dev_io = ~dev_io;
endmodule
`default_nettype wire

// [verification/nfh_host_asserts.sv]
// Purpose: Concurrent checks on the NAND host sequencer pins and answers.
// Assumes: Only top ports are visible; one clock domain.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module nfh_host_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // User answer
    input wire logic       req_ready,
    input wire logic       refused_q,
    // Device pins
    input wire logic       chip_en_n_q,
    input wire logic       cmd_latch_q,
    input wire logic       wr_en_n_q,
    input wire logic       rd_en_n_q,
    input wire logic       wr_prot_n_q,
    input wire logic       ready_busy_line,
    input wire logic [7:0] io_out_q,
    input wire logic       io_oe_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic       cmd_wr;
    logic       strobe_d_q;
    logic       seen_q;
    logic [7:0] cur_cmd_q;
    assign cmd_wr = cmd_latch_q && !wr_en_n_q && !chip_en_n_q;
    // Holds the command of the current or the last command strobe.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cur_cmd_q <= 8'h00;
            seen_q    <= 1'b0;
        end else if (cmd_wr) begin
            cur_cmd_q <= io_out_q;
            seen_q    <= 1'b1;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobe_d_q <= 1'b0;
        end else begin
            strobe_d_q <= cmd_wr;
        end
    end
    sequence s_cmd(logic [7:0] c);
        cmd_wr && !strobe_d_q && io_out_q == c;
    endsequence
    a_init_reset: assert property (cmd_wr && !seen_q |-> io_out_q == 8'hFF)
        else $error("first command after reset is not a reset");
    a_known_cmd: assert property (cmd_wr |-> io_out_q inside {8'h00, 8'h30, 8'h80,
        8'h85, 8'h10, 8'h11, 8'h15, 8'h60, 8'hD0, 8'h70, 8'h71, 8'hFF})
        else $error("undocumented command code issued");
    a_busy_cmds: assert property (cmd_wr && !ready_busy_line |->
        io_out_q inside {8'h70, 8'h71, 8'hFF}) else $error("command issued while busy");
    a_after_serial: assert property (cmd_wr && !strobe_d_q && cur_cmd_q == 8'h80 |->
        io_out_q inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hFF})
        else $error("illegal command after serial input");
    a_wp_on_prog: assert property (cmd_wr && io_out_q inside {8'h10, 8'hD0} |-> wr_prot_n_q)
        else $error("program or erase started while protected");
    a_status_follow: assert property ((s_cmd(8'h10) or s_cmd(8'hD0)) |->
        ##[1:1000] s_cmd(8'h70)) else $error("no status read after program or erase");
    a_read_release: assert property (!rd_en_n_q |-> !io_oe_q)
        else $error("host drives the data port during a read strobe");
    a_refuse_idle: assert property (refused_q |-> req_ready)
        else $error("refusal left the host busy");
endmodule
`default_nettype wire

// [verification/nfh_tb.sv]
// Purpose: Self-checking bench for the NAND host sequencer.
// Assumes: Device model on the pins; 50 MHz clock.
// Notes:   Ordinary requests come from a table; faults and reset follow it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [2:0]  op;
        logic [11:0] blk;
        logic [5:0]  pg;
        logic        ecc;
        logic        fail;
        logic        refd;
    } nfh_row_s;
    localparam logic [2:0] RST = nfh_pkg::NFH_OP_RESET;
    localparam logic [2:0] RD  = nfh_pkg::NFH_OP_READ;
    localparam logic [2:0] PRG = nfh_pkg::NFH_OP_PROGRAM;
    localparam logic [2:0] ERS = nfh_pkg::NFH_OP_ERASE;
    localparam logic [2:0] STA = nfh_pkg::NFH_OP_STATUS;
    localparam logic [2:0] BAD = nfh_pkg::NFH_OP_BADCHK;
    logic        clk, reset, req_valid, req_ready, wr_take, rd_valid_q, ecc_uncorrectable;
    logic        done_q, fail_q, refused_q, chip_en_n_q, cmd_latch_q, addr_latch_q;
    logic        wr_en_n_q, rd_en_n_q, wr_prot_n_q, ready_busy_line, io_oe_q, fail_next;
    logic [2:0]  req_op;
    logic [11:0] req_block, req_col;
    logic [5:0]  req_page;
    logic [7:0]  wr_data, rd_data_q, status_q, io_in, io_out_q, dev_io, last_rd;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;
    int          n_rd = 0;
    nfh_row_s    rows [12];
    assign io_in = io_oe_q ? io_out_q : dev_io;
    nfh_host dut_u (.*, .xfer_len(16'h0004));
    nfh_dev_model dev_u (.chip_en_n(chip_en_n_q), .cmd_latch(cmd_latch_q),
        .addr_latch(addr_latch_q), .wr_en_n(wr_en_n_q), .rd_en_n(rd_en_n_q),
        .wr_prot_n(wr_prot_n_q), .io_bus(io_in), .fail_next(fail_next),
        .ready_busy_line(ready_busy_line), .dev_io(dev_io));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
        if (rd_valid_q === 1'b1) n_rd <= n_rd + 1;
        if (rd_valid_q === 1'b1) last_rd <= rd_data_q;
        cycles++;
        if (cycles == 50000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pins_in_reset();
        check("chip enable", 8'h01, 8'(chip_en_n_q));
        check("write protect", 8'h00, 8'(wr_prot_n_q));
        check("io drive", 8'h00, 8'(io_oe_q));
    endtask
    task automatic run_op(input nfh_row_s r);
        int k;
        @(negedge clk);
        req_op = r.op;
        req_block = r.blk;
        req_page = r.pg;
        ecc_uncorrectable = r.ecc;
        req_valid = 1'b1;
        n_rd = 0;
        k = 0;
        while (!(req_ready === 1'b1 && ready_busy_line === 1'b1) && k < 5000) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        while (done_q !== 1'b1 && refused_q !== 1'b1 && k < 10000) begin
            @(negedge clk);
            k++;
        end
        check("refused", 8'(r.refd), 8'(refused_q));
        check("done", 8'(!r.refd), 8'(done_q));
        if (!r.refd) check("fail", 8'(r.fail), 8'(fail_q));
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        rows = '{'{PRG, 12'h001, 6'h00, 1'b0, 1'b0, 1'b0}, '{PRG, 12'h001, 6'h00, 1'b0, 1'b0, 1'b1},
                 '{PRG, 12'h001, 6'h02, 1'b0, 1'b0, 1'b1}, '{PRG, 12'h001, 6'h01, 1'b0, 1'b0, 1'b0},
                 '{RD,  12'h001, 6'h00, 1'b0, 1'b0, 1'b0}, '{RD,  12'h001, 6'h00, 1'b1, 1'b1, 1'b0},
                 '{STA, 12'h000, 6'h00, 1'b0, 1'b0, 1'b0}, '{BAD, 12'h002, 6'h00, 1'b0, 1'b1, 1'b0},
                 '{ERS, 12'h002, 6'h00, 1'b0, 1'b0, 1'b1}, '{ERS, 12'h001, 6'h00, 1'b0, 1'b0, 1'b0},
                 '{PRG, 12'h001, 6'h00, 1'b0, 1'b0, 1'b0}, '{RST, 12'h000, 6'h00, 1'b0, 1'b0, 1'b0}};
        {req_valid, req_op, req_block, req_page, req_col, ecc_uncorrectable, fail_next} = '0;
        wr_data = 8'h10;
        last_rd = 8'h00;
        reset = 1'b1;
        repeat (3) @(posedge clk);
        pins_in_reset();
        @(negedge clk);
        reset = 1'b0;
        foreach (rows[i]) begin
            run_op(rows[i]);
            if (rows[i].op == RD && !rows[i].refd) check("read count", 8'h04, n_rd[7:0]);
        end
        run_op('{RD, 12'h001, 6'h00, 1'b0, 1'b0, 1'b0});
        check("read data", 8'h1B, last_rd);
        fail_next = 1'b1;
        run_op('{PRG, 12'h003, 6'h00, 1'b0, 1'b1, 1'b0});
        check("status", 8'hE1, status_q);
        fail_next = 1'b0;
        run_op('{PRG, 12'h003, 6'h01, 1'b0, 1'b0, 1'b1});
        fail_next = 1'b1;
        run_op('{ERS, 12'h004, 6'h00, 1'b0, 1'b1, 1'b0});
        fail_next = 1'b0;
        run_op('{RD, 12'h004, 6'h00, 1'b0, 1'b0, 1'b1});
        @(negedge clk);
        req_op = RD;
        req_block = 12'h001;
        req_valid = 1'b1;
        repeat (6) @(negedge clk);
        reset = 1'b1;
        req_valid = 1'b0;
        repeat (3) @(negedge clk);
        pins_in_reset();
        reset = 1'b0;
        run_op('{PRG, 12'h005, 6'h00, 1'b0, 1'b0, 1'b0});
        check("status", 8'hE0, status_q);
        give_verdict();
    end
endmodule
bind nfh_host nfh_host_asserts chk_u (.*);
`default_nettype wire

// [verilog/nfh_host.sv]
// Purpose: Host sequencer that drives an asynchronous NAND flash through its pins.
// Assumes: One clock; device pins are sampled synchronously; ready_busy_line pulled up.
// Notes:   One operation at a time; bad blocks are kept in a local table.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - During initialisation only reset or status read is issued.
// - Only documented command codes are ever issued.
// - While busy only status read, alternate status read or reset is issued.
// - After serial data input only column change, program variants or reset follow.
// - Pages within a block are programmed in ascending order only.
// - No more than four partial programs per page.
// - Block is bad when the marker column reads zero.
// - Blocks marked bad are never erased.
// - Read data passes an eight-bit per 512-byte corrector; status is acted upon.
// - Program failure: data rewritten elsewhere and failing block excluded; the host only sets fail_q and marks the block bad, with no rewrite.
// - Erase failure: block recorded bad and never accessed again.
module nfh_host #(
    parameter int BLOCK_BITS = 12,
    parameter int PAGE_BITS  = 6,
    parameter int COL_BITS   = 12
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // User request
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire logic [2:0]            req_op,
    input  wire logic [BLOCK_BITS-1:0] req_block,
    input  wire logic [PAGE_BITS-1:0]  req_page,
    input  wire logic [COL_BITS-1:0]   req_col,
    // User data
    input  wire logic [7:0]            wr_data,
    output logic                       wr_take,
    output logic [7:0]                 rd_data_q,
    output logic                       rd_valid_q,
    input  wire logic                  ecc_uncorrectable,
    // User answer
    output logic                       done_q,
    output logic [7:0]                 status_q,
    output logic                       fail_q,
    output logic                       refused_q,
    input  wire logic [15:0]           xfer_len,
    // Device pins
    output logic                       chip_en_n_q,
    output logic                       cmd_latch_q,
    output logic                       addr_latch_q,
    output logic                       wr_en_n_q,
    output logic                       rd_en_n_q,
    output logic                       wr_prot_n_q,
    input  wire logic                  ready_busy_line,
    input  wire logic [7:0]            io_in,
    output logic [7:0]                 io_out_q,
    output logic                       io_oe_q
);
    // -------------------------------------------------------------------
    // State and storage
    // -------------------------------------------------------------------
    typedef enum {
        S_INIT, S_INIT_RST, S_IDLE, S_CMD, S_ADDR, S_WDATA, S_WAIT, S_RDATA,
        S_STAT, S_DONE
    } nfh_state_e;

    nfh_state_e                 state_q;
    logic [1:0]                 stb_q;
    logic [7:0]                 cmd_q;
    logic [7:0]                 cmd2_q;
    logic [2:0]                 op_q;
    logic [2:0]                 acnt_q;
    logic [15:0]                dcnt_q;
    logic [39:0]                addr_q;
    logic [(1<<BLOCK_BITS)-1:0] bad_q;
    logic [PAGE_BITS:0]         next_page_q [(1<<BLOCK_BITS)];
    logic [BLOCK_BITS-1:0]      blk_q;
    logic                       started_q;

    // Legal command codes; everything else is never latched.
    function automatic logic known_cmd(input logic [7:0] c);
        known_cmd = c inside {nfh_pkg::CMD_READ, nfh_pkg::CMD_READ_CONF,
            nfh_pkg::CMD_SERIAL_IN, nfh_pkg::CMD_COL_CHANGE, nfh_pkg::CMD_PROG,
            nfh_pkg::CMD_PROG_MULTI, nfh_pkg::CMD_PROG_CACHE, nfh_pkg::CMD_ERASE1,
            nfh_pkg::CMD_ERASE2, nfh_pkg::CMD_STATUS, nfh_pkg::CMD_STATUS_ALT,
            nfh_pkg::CMD_RESET};
    endfunction

    logic stb_end;
    logic ready_now;
    logic refuse;
    logic [23:0] req_row;
    assign stb_end   = (stb_q == 2'(nfh_pkg::STROBE_CYC));
    assign ready_now = ready_busy_line;
    assign req_ready = (state_q == S_IDLE);
    assign wr_take   = (state_q == S_WDATA) && stb_end;
    // Bad blocks are never erased or programmed; page order is strictly ascending.
    assign refuse = bad_q[req_block]
        || ((req_op == 3'(nfh_pkg::NFH_OP_PROGRAM))
            && ({1'b0, req_page} != next_page_q[req_block]));
    assign req_row = {8'(32'(req_block) >> (8 - PAGE_BITS + 8)),
        8'(32'(req_block) >> (8 - PAGE_BITS)),
        8'((32'(req_block) << PAGE_BITS) | 32'(req_page))};

    // -------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q   <= S_INIT;
            stb_q     <= '0;
            cmd_q     <= 8'h00;
            cmd2_q    <= 8'h00;
            op_q      <= 3'h0;
            acnt_q    <= 3'h0;
            dcnt_q    <= 16'h0000;
            addr_q    <= '0;
            blk_q     <= '0;
            started_q <= 1'b0;
            done_q    <= 1'b0;
            fail_q    <= 1'b0;
            refused_q <= 1'b0;
            status_q  <= 8'h00;
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            done_q     <= 1'b0;
            refused_q  <= 1'b0;
            rd_valid_q <= 1'b0;
            stb_q      <= (stb_q == 2'(nfh_pkg::STROBE_CYC)) ? 2'h0 : stb_q + 2'h1;
            unique case (state_q)
                S_INIT: begin
                    stb_q <= '0;
                    if (ready_now) begin
                        cmd_q   <= nfh_pkg::CMD_RESET;
                        cmd2_q  <= 8'h00;
                        acnt_q  <= 3'h0;
                        state_q <= S_CMD;
                        op_q    <= 3'(nfh_pkg::NFH_OP_RESET);
                    end
                end
                S_IDLE: begin
                    stb_q <= '0;
                    if (req_valid && refuse) begin
                        refused_q <= 1'b1;
                    end else if (req_valid && ready_now) begin
                        op_q      <= req_op;
                        blk_q     <= req_block;
                        fail_q    <= 1'b0;
                        started_q <= 1'b0;
                        dcnt_q    <= xfer_len;
                        // Five cycles only: column low/high, row low/mid/high.
                        addr_q <= {req_row, 8'(32'(req_col) >> 8), 8'(req_col)};
                        acnt_q <= nfh_pkg::ADDR_CYCLES[2:0];
                        unique case (req_op)
                            3'(nfh_pkg::NFH_OP_READ),
                            3'(nfh_pkg::NFH_OP_BADCHK): begin
                                cmd_q  <= nfh_pkg::CMD_READ;
                                cmd2_q <= nfh_pkg::CMD_READ_CONF;
                            end
                            3'(nfh_pkg::NFH_OP_PROGRAM): begin
                                cmd_q  <= nfh_pkg::CMD_SERIAL_IN;
                                cmd2_q <= nfh_pkg::CMD_PROG;
                            end
                            3'(nfh_pkg::NFH_OP_ERASE): begin
                                cmd_q  <= nfh_pkg::CMD_ERASE1;
                                cmd2_q <= nfh_pkg::CMD_ERASE2;
                                acnt_q <= 3'h3;
                                addr_q <= {16'h0000, req_row};
                            end
                            3'(nfh_pkg::NFH_OP_STATUS): begin
                                cmd_q  <= nfh_pkg::CMD_STATUS;
                                cmd2_q <= 8'h00;
                                acnt_q <= 3'h0;
                            end
                            default: begin
                                cmd_q  <= nfh_pkg::CMD_RESET;
                                cmd2_q <= 8'h00;
                                acnt_q <= 3'h0;
                            end
                        endcase
                        if (req_op == 3'(nfh_pkg::NFH_OP_BADCHK)) begin
                            dcnt_q <= 16'h0001;
                        end
                        state_q <= S_CMD;
                    end
                end
                S_CMD: begin
                    if (stb_end) begin
                        if (acnt_q != 3'h0 && !started_q) begin
                            state_q <= S_ADDR;
                        end else if (started_q) begin
                            state_q <= S_WAIT;
                        end else begin
                            state_q <= (cmd_q == nfh_pkg::CMD_STATUS) ? S_STAT : S_WAIT;
                        end
                    end
                end
                S_ADDR: begin
                    if (stb_end) begin
                        addr_q <= {8'h00, addr_q[39:8]};
                        acnt_q <= acnt_q - 3'h1;
                        if (acnt_q == 3'h1) begin
                            if (op_q == 3'(nfh_pkg::NFH_OP_PROGRAM)) begin
                                state_q <= S_WDATA;
                            end else begin
                                cmd_q     <= cmd2_q;
                                started_q <= 1'b1;
                                state_q   <= S_CMD;
                            end
                        end
                    end
                end
                S_WDATA: begin
                    if (stb_end) begin
                        dcnt_q <= dcnt_q - 16'h0001;
                        if (dcnt_q == 16'h0001) begin
                            cmd_q     <= cmd2_q;
                            started_q <= 1'b1;
                            state_q   <= S_CMD;
                        end
                    end
                end
                S_WAIT: begin
                    stb_q <= '0;
                    if (ready_now) begin
                        if (op_q == 3'(nfh_pkg::NFH_OP_READ)
                            || op_q == 3'(nfh_pkg::NFH_OP_BADCHK)) begin
                            state_q <= S_RDATA;
                        end else begin
                            cmd_q   <= nfh_pkg::CMD_STATUS;
                            cmd2_q  <= 8'h00;
                            acnt_q  <= 3'h0;
                            started_q <= 1'b0;
                            state_q <= S_CMD;
                        end
                    end
                end
                S_RDATA: begin
                    if (stb_end) begin
                        rd_data_q  <= io_in;
                        rd_valid_q <= 1'b1;
                        dcnt_q     <= dcnt_q - 16'h0001;
                        if (op_q == 3'(nfh_pkg::NFH_OP_BADCHK)) begin
                            fail_q <= (io_in == nfh_pkg::BAD_MARK);
                        end
                        if (dcnt_q == 16'h0001) begin
                            state_q <= S_DONE;
                        end
                    end
                end
                S_STAT: begin
                    if (stb_end) begin
                        status_q <= io_in;
                        if (io_in[nfh_pkg::ST_READY_BIT]) begin
                            fail_q  <= io_in[nfh_pkg::ST_FAIL1_BIT]
                                       | io_in[nfh_pkg::ST_FAIL2_BIT];
                            state_q <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    stb_q   <= '0;
                    done_q  <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
            if (rd_valid_q && ecc_uncorrectable) begin
                fail_q <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Bad block table and page order tracking
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bad_q <= '0;
        end else if (state_q == S_DONE && fail_q
                     && op_q != 3'(nfh_pkg::NFH_OP_READ)
                     && op_q != 3'(nfh_pkg::NFH_OP_RESET)
                     && op_q != 3'(nfh_pkg::NFH_OP_STATUS)) begin
            bad_q[blk_q] <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < (1 << BLOCK_BITS); i++) begin
                next_page_q[i] <= '0;
            end
        end else if (state_q == S_DONE && !fail_q) begin
            if (op_q == 3'(nfh_pkg::NFH_OP_ERASE)) begin
                next_page_q[blk_q] <= '0;
            end else if (op_q == 3'(nfh_pkg::NFH_OP_PROGRAM)) begin
                next_page_q[blk_q] <= next_page_q[blk_q] + (PAGE_BITS+1)'(1);
            end
        end
    end

    // -------------------------------------------------------------------
    // Pin drive
    // -------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chip_en_n_q  <= 1'b1;
            cmd_latch_q  <= 1'b0;
            addr_latch_q <= 1'b0;
            wr_en_n_q    <= 1'b1;
            rd_en_n_q    <= 1'b1;
            wr_prot_n_q  <= 1'b0;
            io_out_q     <= 8'h00;
            io_oe_q      <= 1'b0;
        end else begin
            wr_prot_n_q  <= (state_q != S_INIT);
            chip_en_n_q  <= (state_q == S_IDLE) || (state_q == S_INIT);
            cmd_latch_q  <= (state_q == S_CMD);
            addr_latch_q <= (state_q == S_ADDR);
            wr_en_n_q    <= !((state_q == S_CMD || state_q == S_ADDR
                              || state_q == S_WDATA) && !stb_q[1]);
            rd_en_n_q    <= !((state_q == S_RDATA || state_q == S_STAT) && !stb_q[1]);
            io_oe_q      <= (state_q == S_CMD || state_q == S_ADDR || state_q == S_WDATA);
            io_out_q     <= (state_q == S_CMD && known_cmd(cmd_q)) ? cmd_q
                          : (state_q == S_ADDR) ? addr_q[7:0]
                          : (state_q == S_WDATA) ? wr_data : 8'h00;
        end
    end
endmodule

`default_nettype wire

// [verilog/nfh_pkg.sv]
// Purpose: Constants for the NAND flash host sequencer.
// Assumes: Eight-bit asynchronous NAND device with an open-drain ready/busy line.
// Notes:   Command codes and status bit positions are used by the design; the bench takes only the operation codes.
package nfh_pkg;
    // -------------------------------------------------------------------
    // Command codes
    // -------------------------------------------------------------------
    localparam logic [7:0] CMD_READ       = 8'h00;
    localparam logic [7:0] CMD_READ_CONF  = 8'h30;
    localparam logic [7:0] CMD_SERIAL_IN  = 8'h80;
    localparam logic [7:0] CMD_COL_CHANGE = 8'h85;
    localparam logic [7:0] CMD_PROG       = 8'h10;
    localparam logic [7:0] CMD_PROG_MULTI = 8'h11;
    localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
    localparam logic [7:0] CMD_ERASE1     = 8'h60;
    localparam logic [7:0] CMD_ERASE2     = 8'hD0;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_STATUS_ALT = 8'h71;
    localparam logic [7:0] CMD_RESET      = 8'hFF;
    // -------------------------------------------------------------------
    // Status bits and markers
    // -------------------------------------------------------------------
    localparam int         ST_FAIL1_BIT   = 0;
    localparam int         ST_FAIL2_BIT   = 1;
    localparam int         ST_READY_BIT   = 5;
    localparam int         ST_CREADY_BIT  = 6;
    localparam logic [7:0] BAD_MARK       = 8'h00;
    localparam int         MAX_PARTIAL    = 4;
    // -------------------------------------------------------------------
    // Operation codes of the user port
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        NFH_OP_RESET,
        NFH_OP_READ,
        NFH_OP_PROGRAM,
        NFH_OP_ERASE,
        NFH_OP_STATUS,
        NFH_OP_BADCHK
    } nfh_op_e;
    // -------------------------------------------------------------------
    // Pin timing
    // -------------------------------------------------------------------
    localparam int         CLK_NS         = 20;
    localparam int         STROBE_NS      = 40;
    localparam int         STROBE_CYC     = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] ADDR_CYCLES    = 8'h05;
endpackage
